// file: shared/dlc_defs.svh
// Constants for the dual-channel output control register bank.
`ifndef DLC_DEFS_SVH
`define DLC_DEFS_SVH
`define DLC_SEL_LEVEL_CH1 2'h0
`define DLC_SEL_LEVEL_CH2 2'h1
`define DLC_SEL_TONE_CH1 2'h2
`define DLC_SEL_TONE_CH2 2'h3
`define DLC_SEL_HI 7
`define DLC_SEL_LO 6
`define DLC_LVL_CODE_HI 3
`define DLC_LVL_RANGE 3
`define DLC_LVL_ODT 4
`define DLC_LVL_ON 5
`define DLC_TONE_SRC 0
`define DLC_TONE_PASS 1
`define DLC_TONE_CTEST 2
`define DLC_LVL_MASK 6'h3F
`define DLC_TONE_MASK 6'h07
`define DLC_RESET_VAL 6'h00
`endif

// file: shared/dlc_pkg.sv
// Types for the dual-channel output control register bank.
package dlc_pkg;
  typedef struct packed {
    logic [3:0] level_code;
    logic range_select;
    logic output_on;
    logic oc_disable_timer_en;
    logic tone_out;
    logic cable_test_on;
    logic linreg_disable;
    logic test_current_en;
    logic boost_raise;
    logic cable_missing_flag;
  } dlc_chan_ctrl_t;
endpackage : dlc_pkg

// file: logic/dlc_ctrl_regs.sv
// Write-side control register bank for two output channels.
`timescale 1ns/1ns
`include "dlc_defs.svh"
module dlc_ctrl_regs (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_stb_i,
  input wire logic [7:0] wr_byte_i,
  input wire logic ext_tone_i,
  input wire logic int_tone_i,
  input wire logic [1:0] ext_mod_gating_i,
  input wire logic [1:0] cmp_above_set_i,
  input wire logic [1:0] cmp_below_clr_i,
  output dlc_pkg::dlc_chan_ctrl_t ch1_o,
  output dlc_pkg::dlc_chan_ctrl_t ch2_o
);
  // Stored data bits of the level and tone/test registers, one entry per channel.
  logic [5:0] lvl_q [2];
  logic [5:0] lvl_d [2];
  logic [5:0] tone_q [2];
  logic [5:0] tone_d [2];

  // Two-stage synchronisers; only the second stage feeds any logic.
  logic [1:0] ext_tone_s_q;
  logic [1:0] ext_tone_s_d;
  logic [1:0] mod_s1_q;
  logic [1:0] mod_s1_d;
  logic [1:0] mod_s2_q;
  logic [1:0] mod_s2_d;
  logic [1:0] above_s1_q;
  logic [1:0] above_s1_d;
  logic [1:0] above_s2_q;
  logic [1:0] above_s2_d;
  logic [1:0] below_s1_q;
  logic [1:0] below_s1_d;
  logic [1:0] below_s2_q;
  logic [1:0] below_s2_d;

  // Cable-missing flags, one per channel.
  logic [1:0] missing_q;
  logic [1:0] missing_d;

  // Registered channel outputs.
  dlc_pkg::dlc_chan_ctrl_t out_q [2];
  dlc_pkg::dlc_chan_ctrl_t out_d [2];

  // True when a write strobe carries the given register select code.
  function automatic logic reg_hit(input logic stb, input logic [7:0] b, input logic [1:0] code);
    reg_hit = stb && (b[`DLC_SEL_HI:`DLC_SEL_LO] == code);
  endfunction : reg_hit

  // Select code of the level register that belongs to a channel.
  function automatic logic [1:0] level_sel_of(input int c);
    level_sel_of = (c == 0) ? `DLC_SEL_LEVEL_CH1 : `DLC_SEL_LEVEL_CH2;
  endfunction : level_sel_of

  // Select code of the tone/test register that belongs to a channel.
  function automatic logic [1:0] tone_sel_of(input int c);
    tone_sel_of = (c == 0) ? `DLC_SEL_TONE_CH1 : `DLC_SEL_TONE_CH2;
  endfunction : tone_sel_of

  // Picks the tone source and applies the gate; modulation gating forces the tone through.
  function automatic logic tone_gate(input logic [5:0] t, input logic int_tone, input logic ext_tone,
                                     input logic mod_gate);
    logic src;
    src = t[`DLC_TONE_SRC] ? int_tone : ext_tone;
    tone_gate = src & (mod_gate | t[`DLC_TONE_PASS]);
  endfunction : tone_gate

  // Synchroniser group.
  always_comb begin
    ext_tone_s_d = {ext_tone_s_q[0], ext_tone_i};
    mod_s1_d = ext_mod_gating_i;
    mod_s2_d = mod_s1_q;
    above_s1_d = cmp_above_set_i;
    above_s2_d = above_s1_q;
    below_s1_d = cmp_below_clr_i;
    below_s2_d = below_s1_q;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_tone_s_q <= 2'h0;
      mod_s1_q <= 2'h0;
      mod_s2_q <= 2'h0;
      above_s1_q <= 2'h0;
      above_s2_q <= 2'h0;
      below_s1_q <= 2'h0;
      below_s2_q <= 2'h0;
    end else begin
      ext_tone_s_q <= ext_tone_s_d;
      mod_s1_q <= mod_s1_d;
      mod_s2_q <= mod_s2_d;
      above_s1_q <= above_s1_d;
      above_s2_q <= above_s2_d;
      below_s1_q <= below_s1_d;
      below_s2_q <= below_s2_d;
    end
  end

  // Register group.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      lvl_d[c] = lvl_q[c];
      tone_d[c] = tone_q[c];
      if (reg_hit(wr_stb_i, wr_byte_i, level_sel_of(c))) begin
        lvl_d[c] = wr_byte_i[5:0] & `DLC_LVL_MASK;
      end
      if (reg_hit(wr_stb_i, wr_byte_i, tone_sel_of(c))) begin
        tone_d[c] = wr_byte_i[5:0] & `DLC_TONE_MASK;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int c = 0; c < 2; c++) begin
        lvl_q[c] <= `DLC_RESET_VAL;
        tone_q[c] <= `DLC_RESET_VAL;
      end
    end else begin
      lvl_q <= lvl_d;
      tone_q <= tone_d;
    end
  end

  // Flag group; a set event wins over a clear event in the same cycle.
  always_comb begin
    missing_d = missing_q;
    for (int c = 0; c < 2; c++) begin
      if (!tone_q[c][`DLC_TONE_CTEST]) begin
        missing_d[c] = 1'b0;
      end else if (above_s2_q[c]) begin
        missing_d[c] = 1'b1;
      end else if (below_s2_q[c]) begin
        missing_d[c] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      missing_q <= 2'h0;
    end else begin
      missing_q <= missing_d;
    end
  end

  // Output group.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      out_d[c].level_code = lvl_q[c][`DLC_LVL_CODE_HI:0];
      out_d[c].range_select = lvl_q[c][`DLC_LVL_RANGE];
      out_d[c].output_on = lvl_q[c][`DLC_LVL_ON];
      out_d[c].oc_disable_timer_en = 1'b1;
      out_d[c].tone_out = tone_gate(tone_q[c], int_tone_i, ext_tone_s_q[1], mod_s2_q[c]);
      out_d[c].cable_test_on = tone_q[c][`DLC_TONE_CTEST];
      out_d[c].linreg_disable = tone_q[c][`DLC_TONE_CTEST];
      out_d[c].test_current_en = tone_q[c][`DLC_TONE_CTEST];
      out_d[c].boost_raise = tone_q[c][`DLC_TONE_CTEST];
      out_d[c].cable_missing_flag = missing_q[c];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int c = 0; c < 2; c++) begin
        out_q[c] <= '0;
      end
    end else begin
      out_q <= out_d;
    end
  end

  // Both channel ports come straight from the output flip-flops.
  assign ch1_o = out_q[0];
  assign ch2_o = out_q[1];
endmodule : dlc_ctrl_regs

// file: tb/dlc_host_model.sv
// Host model that hands single bytes to the register bank.
`timescale 1ns/1ns
module dlc_host_model (
  input wire logic clk_i,
  output logic wr_stb_o = 1'h0,
  output logic [7:0] wr_byte_o = 8'h00
);
  task automatic send(input logic [7:0] b);
    @(negedge clk_i);
    wr_stb_o = 1'h1;
    wr_byte_o = b;
    @(negedge clk_i);
    wr_stb_o = 1'h0;
    wr_byte_o = ~b;
  endtask : send
endmodule : dlc_host_model

// file: tb/dlc_ctrl_regs_chk.sv
// Port assertions for the control register bank.
`timescale 1ns/1ns
module dlc_ctrl_regs_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_stb_i,
  input wire logic [7:0] wr_byte_i,
  input wire logic ext_tone_i,
  input wire logic int_tone_i,
  input wire logic [1:0] ext_mod_gating_i,
  input wire logic [1:0] cmp_above_set_i,
  input wire logic [1:0] cmp_below_clr_i,
  input wire dlc_pkg::dlc_chan_ctrl_t ch1_o,
  input wire dlc_pkg::dlc_chan_ctrl_t ch2_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_lvl_write: assert property (wr_stb_i && wr_byte_i[7:6] == 2'h0 |->
    ##2 ch1_o[12:7] == $past({wr_byte_i[3:0], wr_byte_i[3], wr_byte_i[5]}, 2)) else $error("ch1 level");
  a_lvl_write2: assert property (wr_stb_i && wr_byte_i[7:6] == 2'h1 |->
    ##2 ch2_o[12:7] == $past({wr_byte_i[3:0], wr_byte_i[3], wr_byte_i[5]}, 2)) else $error("ch2 level");
  a_test_bit: assert property (wr_stb_i && wr_byte_i[7:6] == 2'h2 |->
    ##2 ch1_o.cable_test_on == $past(wr_byte_i[2], 2)) else $error("test bit");
  a_test_bit2: assert property (wr_stb_i && wr_byte_i[7:6] == 2'h3 |->
    ##2 ch2_o.cable_test_on == $past(wr_byte_i[2], 2)) else $error("ch2 test bit");
  a_test_ctrl: assert property (ch1_o[3:1] == {3{ch1_o.cable_test_on}}) else $error("test controls");
  a_test_ctrl2: assert property (ch2_o[3:1] == {3{ch2_o.cable_test_on}}) else $error("ch2 test controls");
  a_timer_on: assert property (!$past(srst_i) && !$past(srst_i, 2) |-> ch2_o.oc_disable_timer_en)
    else $error("timer off");
  a_flag_set: assert property ((ch1_o.cable_test_on && cmp_above_set_i[0])[*6] |-> ch1_o.cable_missing_flag)
    else $error("flag set");
  a_flag_set2: assert property ((ch2_o.cable_test_on && cmp_above_set_i[1])[*6] |-> ch2_o.cable_missing_flag)
    else $error("ch2 flag set");
  a_flag_clr: assert property ((ch1_o.cable_test_on && cmp_below_clr_i[0] && !cmp_above_set_i[0])[*6] |->
    !ch1_o.cable_missing_flag) else $error("flag clear");
  a_flag_off: assert property ((!ch1_o.cable_test_on)[*2] |-> !ch1_o.cable_missing_flag) else $error("flag off");
  a_sel_only: assert property (wr_stb_i && wr_byte_i[7:6] != 2'h0 && !$past(wr_stb_i) |->
    ##2 $stable(ch1_o[12:7])) else $error("other register");
endmodule : dlc_ctrl_regs_chk
bind dlc_ctrl_regs dlc_ctrl_regs_chk u_chk (.*);

// file: tb/dlc_ctrl_regs_tb.sv
// Bench for the control register bank.
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; $display("unexpected %0t %h %h", $time, a, e); end end
module dlc_ctrl_regs_tb;
  logic clk_i = 1'h0, srst_i = 1'h1, wr_stb_i, ext_tone_i = 1'h0, int_tone_i = 1'h0;
  logic [7:0] wr_byte_i;
  logic [1:0] ext_mod_gating_i = 2'h0, cmp_above_set_i = 2'h0, cmp_below_clr_i = 2'h0;
  dlc_pkg::dlc_chan_ctrl_t ch1_o, ch2_o;
  int num_errors = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  dlc_host_model u_host (.clk_i(clk_i), .wr_stb_o(wr_stb_i), .wr_byte_o(wr_byte_i));
  dlc_ctrl_regs u_dut (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .wr_stb_i(wr_stb_i),
    .wr_byte_i(wr_byte_i),
    .ext_tone_i(ext_tone_i),
    .int_tone_i(int_tone_i),
    .ext_mod_gating_i(ext_mod_gating_i),
    .cmp_above_set_i(cmp_above_set_i),
    .cmp_below_clr_i(cmp_below_clr_i),
    .ch1_o(ch1_o),
    .ch2_o(ch2_o)
  );
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Write a byte, then set tone and comparator inputs and let them settle.
  task automatic put(input logic [7:0] b, input logic [3:0] s);
    u_host.send(b);
    {int_tone_i, ext_tone_i, cmp_below_clr_i[0], cmp_above_set_i[0]} = s;
    repeat (8) @(negedge clk_i);
  endtask : put
  initial begin
    #20000;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (6) @(negedge clk_i);
    srst_i = 1'h0;
    put(8'h00, 4'h0);
    `CHK({ch1_o, ch2_o}, {2{13'h040}})
    for (int c = 0; c < 16; c++) begin
      put({4'h2, c[3:0]}, 4'h0);
      `CHK(ch1_o[12:7], {c[3:0], c[3], 1'h1})
    end
    put(8'h5F, 4'h0);
    `CHK({ch2_o[12:6], ch1_o[12:7]}, {4'hF, 3'h5, 4'hF, 2'h3})
    $display("levels done");
    put(8'h84, 4'h1);
    `CHK(ch1_o[4:0], 5'h1F)
    put(8'h84, 4'h2);
    `CHK(ch1_o[4:0], 5'h1E)
    put(8'h80, 4'h1);
    `CHK(ch1_o[4:0], 5'h00)
    put(8'h6F, 4'h0);
    cmp_above_set_i[1] = 1'h1;
    put(8'hC4, 4'h0);
    `CHK(ch2_o[4:0], 5'h1F)
    cmp_above_set_i[1] = 1'h0;
    cmp_below_clr_i[1] = 1'h1;
    put(8'hC4, 4'h0);
    `CHK(ch2_o[4:0], 5'h1E)
    cmp_below_clr_i[1] = 1'h0;
    put(8'hC3, 4'h8);
    `CHK(ch2_o.tone_out, 1'h1)
    put(8'hC3, 4'h4);
    `CHK(ch2_o.tone_out, 1'h0)
    put(8'hC2, 4'h4);
    `CHK(ch2_o.tone_out, 1'h1)
    put(8'hC1, 4'h8);
    `CHK(ch2_o.tone_out, 1'h0)
    ext_mod_gating_i = 2'h2;
    put(8'hC0, 4'h4);
    `CHK(ch2_o.tone_out, 1'h1)
    put(8'h83, 4'h8);
    `CHK({ch1_o.tone_out, ch1_o.cable_missing_flag}, 2'h2)
    $display("cable and tone done");
    ext_mod_gating_i = 2'h0;
    srst_i = 1'h1;
    repeat (3) @(negedge clk_i);
    `CHK({ch1_o, ch2_o}, 26'h0)
    srst_i = 1'h0;
    put(8'hC0, 4'h0);
    `CHK({ch1_o, ch2_o}, {2{13'h040}})
    $display("reset done");
    end_sim();
  end
endmodule : dlc_ctrl_regs_tb
